// ===== testbench/pcfg_host_model.sv
// Purpose: Host software model issuing config and non-config accesses
// Assumes: Requests change at the falling edge, one request then one idle cycle
// Notes: Released offset and data are inverted so stale values never pass
`timescale 1ns/1ps
module pcfg_host_model (
  // Clock
  input wire logic sys_clk,
  // Config request
  output logic cfg_req,
  output logic cfg_we,
  output logic cfg_ext,
  output logic [2:0] cfg_dev,
  output logic [11:0] cfg_off,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  // Non-config request
  output logic acc_req,
  output logic acc_we,
  output logic [2:0] acc_dev
);
  initial begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_ext = 1'b0;
    cfg_dev = 3'h0;
    cfg_off = 12'h000;
    cfg_be = 4'hf;
    cfg_wdata = 32'h0000_0000;
    acc_req = 1'b0;
    acc_we = 1'b0;
    acc_dev = 3'h0;
  end

  task automatic cfg_op(input logic we, input logic ext, input logic [2:0] dev,
                        input logic [11:0] off, input logic [31:0] wdata);
    @(negedge sys_clk);
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_ext = ext;
    cfg_dev = dev;
    cfg_off = off;
    cfg_wdata = wdata;
    @(negedge sys_clk);
    cfg_req = 1'b0;
    cfg_off = ~cfg_off;
    cfg_wdata = ~cfg_wdata;
  endtask : cfg_op

  task automatic acc_op(input logic we, input logic [2:0] dev);
    @(negedge sys_clk);
    acc_req = 1'b1;
    acc_we = we;
    acc_dev = dev;
    @(negedge sys_clk);
    acc_req = 1'b0;
    acc_dev = ~acc_dev;
  endtask : acc_op
endmodule : pcfg_host_model

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the port config space
// Assumes: Answers one cycle after each request, checked at the falling edge
// Notes: Expected answers queue up in request order
`timescale 1ns/1ps
`include "pcfg_params.svh"
module tb;
  typedef struct packed {logic abort; logic [31:0] mask; logic [31:0] data;} pcfg_exp_t;
  logic sys_clk, rst_n, train_done, legacy_mode, cfg_req, cfg_we, cfg_ext, acc_req, acc_we;
  logic cfg_ack_q, cfg_abort_q, acc_ack_q, acc_abort_q;
  logic [7:0][1:0] tw;
  logic [2:0] cfg_dev, acc_dev;
  logic [11:0] cfg_off;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata_q, acc_rdata_q, r;
  logic [7:0] acc_fwd_q, err, rmsg, hp, dn, hub_intx_q, msg_fwd_q, port_absorbed_q;
  int fails, tests_run, seed;
  pcfg_exp_t exp_q[$];
  pcfg_exp_t e;

  pcfg_host_model host (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_ext(cfg_ext), .cfg_dev(cfg_dev), .cfg_off(cfg_off), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .acc_req(acc_req), .acc_we(acc_we), .acc_dev(acc_dev));

  pcfg_port_space #(.WRK_DEPTH(`PCFG_WRK_DEPTH)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .train_done(train_done), .train_width(tw), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_ext(cfg_ext), .cfg_dev(cfg_dev), .cfg_off(cfg_off), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack_q(cfg_ack_q), .cfg_abort_q(cfg_abort_q),
    .cfg_rdata_q(cfg_rdata_q), .acc_req(acc_req), .acc_we(acc_we), .acc_dev(acc_dev),
    .acc_ack_q(acc_ack_q), .acc_abort_q(acc_abort_q), .acc_rdata_q(acc_rdata_q),
    .acc_fwd_q(acc_fwd_q), .port_err_evt(err), .root_err_msg(rmsg), .hotplug_powermgmt_events_evt(hp),
    .legacy_mode(legacy_mode), .dn_msg(dn), .hub_intx_q(hub_intx_q),
    .msg_fwd_q(msg_fwd_q), .port_absorbed_q(port_absorbed_q));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [32:0] got, input logic [32:0] want);
    tests_run++;
    if (got !== want) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask : check

  task automatic close_out();
    // An answer that never came leaves its note behind
    if (exp_q.size() != 0) fails++;
    $display("counts: %0d compared, %0d mismatched", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic rd(input logic ext, input logic [2:0] dev, input logic [11:0] off,
                    input logic abort, input logic [31:0] mask, input logic [31:0] data);
    exp_q.push_back('{abort, mask, data});
    host.cfg_op(1'b0, ext, dev, off, 32'h0000_0000);
  endtask : rd

  task automatic wr(input logic [2:0] dev, input logic [11:0] off, input logic [31:0] d);
    exp_q.push_back('{1'b0, 32'h0000_0000, 32'h0000_0000});
    host.cfg_op(1'b1, 1'b0, dev, off, d);
  endtask : wr

  // Both answer kinds share the queue since requests never overlap
  always @(negedge sys_clk) begin
    if (cfg_ack_q === 1'b1 || acc_ack_q === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      if (cfg_ack_q === 1'b1) begin
        check({cfg_abort_q, cfg_rdata_q & e.mask}, {e.abort, e.data & e.mask});
      end else begin
        check({acc_abort_q, acc_rdata_q}, {e.abort, e.data});
        // Non-config notes keep the expected forward pattern in the mask field
        check(acc_fwd_q, e.mask[7:0]);
      end
    end
  end

  initial begin
    #200000;
    fails++;
    close_out();
  end

  initial begin
    seed = 11866;
    rst_n = 1'b0;
    train_done = 1'b0;
    tw = '0;
    legacy_mode = 1'b0;
    {err, rmsg, hp, dn} = 32'h0000_0000;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(1'b0, 3'h2, `PCFG_OFF_CMD, 1'b0, 32'h0000_ffff, 32'h0000_0000);
    wr(3'h2, `PCFG_OFF_CMD, 32'hffff_ffff);
    rd(1'b0, 3'h2, `PCFG_OFF_CMD, 1'b0, 32'h0000_ffff, 32'h0000_0400);
    rd(1'b0, 3'h3, `PCFG_OFF_CMD, 1'b0, 32'h0000_ffff, 32'h0000_0000);
    rd(1'b0, 3'h0, `PCFG_OFF_CMD, 1'b0, 32'h0000_ffff, 32'h0000_0000);
    rd(1'b0, 3'h1, `PCFG_OFF_CMD, 1'b1, 32'hffff_ffff, 32'hffff_ffff);
    $display("test command register done");
    rd(1'b0, 3'h4, `PCFG_OFF_CAPPTR, 1'b0, 32'h0000_00ff, 32'h0000_0050);
    rd(1'b0, 3'h4, `PCFG_OFF_MSI, 1'b0, 32'h0000_ffff, 32'h0000_6005);
    rd(1'b0, 3'h4, `PCFG_OFF_PEX, 1'b0, 32'h0000_ffff, 32'h0000_7010);
    rd(1'b0, 3'h4, `PCFG_OFF_HP, 1'b0, 32'h0000_ffff, 32'h0000_000c);
    rd(1'b1, 3'h7, `PCFG_OFF_EXT, 1'b0, 32'hffff_ffff, 32'h0001_0001);
    rd(1'b0, 3'h7, `PCFG_OFF_EXT, 1'b0, 32'hffff_ffff, 32'h0000_0000);
    $display("test capability layout done");
    r = $random(seed);
    wr(3'h5, `PCFG_OFF_WSEL, 32'h0000_0003);
    wr(3'h5, `PCFG_OFF_WDAT, r);
    wr(3'h5, `PCFG_OFF_WSEL, 32'h0000_0004);
    rd(1'b0, 3'h5, `PCFG_OFF_WDAT, 1'b0, 32'h0000_00ff, 32'h0000_0000);
    wr(3'h5, `PCFG_OFF_WSEL, 32'h0000_0003);
    rd(1'b0, 3'h5, `PCFG_OFF_WDAT, 1'b0, 32'hffff_ffff, r);
    $display("test working registers done");
    @(negedge sys_clk);
    tw[0] = pcfg_pkg::w_x16;
    tw[2] = pcfg_pkg::w_x8;
    tw[4] = pcfg_pkg::w_x16;
    train_done = 1'b1;
    @(negedge sys_clk);
    train_done = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(port_absorbed_q, 8'he8);
    for (int d = 0; d < 8; d++) begin
      exp_q.push_back('{d == 1 || d == 3 || d > 4,
                        (d == 1 || d == 3 || d > 4) ? 32'h0000_0000 : 32'h0000_0001 << d,
                        (d == 1 || d == 3 || d > 4) ? 32'hffff_ffff : 32'h0000_0000});
      host.acc_op(d[0], d[2:0]);
    end
    rd(1'b0, 3'h3, `PCFG_OFF_CMD, 1'b0, 32'h0000_ffff, 32'h0000_0000);
    rd(1'b0, 3'h6, `PCFG_OFF_CAPPTR, 1'b0, 32'h0000_00ff, 32'h0000_0050);
    $display("test port merging done");
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      err = $random(seed);
      rmsg = $random(seed);
      hp = $random(seed);
      dn = $random(seed);
      legacy_mode = i[0];
      @(negedge sys_clk);
      check(hub_intx_q & 8'hfd, (err | rmsg | (hp & {8{legacy_mode}})) & 8'hf9);
      check(msg_fwd_q, dn);
    end
    $display("test legacy interrupts done");
    repeat (3) @(negedge sys_clk);
    close_out();
  end
endmodule : tb

// ===== verilog/pcfg_cmd_bank.sv
// Purpose: One command register per device, only the interrupt inhibit bit stored
// Assumes: Writes arrive already decoded to a valid device
// Notes: Other command bits are outside this block and read as zero here
`timescale 1ns/1ps
`include "pcfg_params.svh"
module pcfg_cmd_bank (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Decoder side
  pcfg_cmd_if.bank cmd
);
  logic [7:0] inh_q;
  logic [7:0] inh_d;

  always_comb begin
    inh_d = inh_q;
    // Bit 10 lives in the upper byte lane
    if (cmd.wr_en && cmd.wr_be[1]) begin
      inh_d[cmd.wr_dev] = cmd.wr_data[`PCFG_CMD_INHIBIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      inh_q <= 8'h00;
    end else begin
      inh_q <= inh_d;
    end
  end

  // Bits 15:11 and all others read zero
  always_comb begin
    cmd.rd_data = 16'h0000;
    cmd.rd_data[`PCFG_CMD_INHIBIT] = inh_q[cmd.rd_dev];
  end
  assign cmd.inhibit = inh_q;
endmodule : pcfg_cmd_bank

// ===== verilog/pcfg_cmd_if.sv
// Purpose: Carrier between the decoder and the command register bank
// Assumes: Single clock domain
// Notes: Read is combinational; the top registers the answer
`timescale 1ns/1ps
interface pcfg_cmd_if;
  logic wr_en;
  logic [2:0] wr_dev;
  logic [15:0] wr_data;
  logic [1:0] wr_be;
  logic [2:0] rd_dev;
  logic [15:0] rd_data;
  logic [7:0] inhibit;
  modport bank (input wr_en, wr_dev, wr_data, wr_be, rd_dev, output rd_data, inhibit);
  modport user (output wr_en, wr_dev, wr_data, wr_be, rd_dev, input rd_data, inhibit);
endinterface : pcfg_cmd_if

// ===== verilog/pcfg_params.svh
// Purpose: Offsets, field positions, reset values and codes of the port config space
// Assumes: Byte offsets within a 4 KB configuration space per device
// Notes: Capability placement below 0x100 is a local layout choice
`ifndef PCFG_PARAMS_SVH
`define PCFG_PARAMS_SVH
`define PCFG_NUM_DEV 8
`define PCFG_SB_DEV 3'h0
`define PCFG_FIRST_PORT 3'h2
`define PCFG_OFF_CMD 12'h004
`define PCFG_OFF_CAPPTR 12'h034
`define PCFG_OFF_MSI 12'h050
`define PCFG_OFF_PEX 12'h060
`define PCFG_OFF_HP 12'h070
`define PCFG_OFF_WSEL 12'h074
`define PCFG_OFF_WDAT 12'h078
`define PCFG_OFF_EXT 12'h100
`define PCFG_ID_MSI 8'h05
`define PCFG_ID_PEX 8'h10
`define PCFG_ID_HP 8'h0c
`define PCFG_EXT_ID 16'h0001
`define PCFG_EXT_VER 4'h1
`define PCFG_CMD_RESET 16'h0000
`define PCFG_CMD_INHIBIT 10
`define PCFG_WRK_DEPTH 8
`define PCFG_ALL_ONES 32'hffff_ffff
`endif

// ===== verilog/pcfg_pkg.sv
// Purpose: Types shared by the port config space modules
// Assumes: Nothing beyond the header
// Notes: Width codes are ordered so a compare finds x8 or wider
package pcfg_pkg;
  typedef enum logic [1:0] {w_x4, w_x8, w_x16} pcfg_width_t;
endpackage : pcfg_pkg

// ===== verilog/pcfg_port_space.sv
// Purpose: Per-port config space decode, link merging and legacy interrupt gate
// Assumes: All inputs come from logic on sys_clk; one access per cycle per port
// Notes: Answers come one cycle after the request
`timescale 1ns/1ps
`include "pcfg_params.svh"
module pcfg_port_space #(
  parameter int WRK_DEPTH = `PCFG_WRK_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link training results
  input wire logic train_done,
  input wire logic [7:0][1:0] train_width,
  // Configuration access
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic cfg_ext,
  input wire logic [2:0] cfg_dev,
  input wire logic [11:0] cfg_off,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack_q,
  output logic cfg_abort_q,
  output logic [31:0] cfg_rdata_q,
  // Non-configuration access
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [2:0] acc_dev,
  output logic acc_ack_q,
  output logic acc_abort_q,
  output logic [31:0] acc_rdata_q,
  output logic [7:0] acc_fwd_q,
  // Interrupt sources and upstream requests
  input wire logic [7:0] port_err_evt,
  input wire logic [7:0] root_err_msg,
  input wire logic [7:0] hotplug_powermgmt_events_evt,
  input wire logic legacy_mode,
  input wire logic [7:0] dn_msg,
  output logic [7:0] hub_intx_q,
  output logic [7:0] msg_fwd_q,
  // Status
  output logic [7:0] port_absorbed_q
);
  localparam int SW = $clog2(WRK_DEPTH);

  pcfg_cmd_if cmd_if ();
  pcfg_cmd_bank u_bank (.sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd_if));

  // Link width capture, once per reset
  pcfg_pkg::pcfg_width_t width_q [8];
  pcfg_pkg::pcfg_width_t width_d [8];
  logic trained_q, trained_d;
  logic [7:0] absorbed;

  always_comb begin
    trained_d = trained_q | train_done;
    for (int i = 0; i < 8; i++) begin
      width_d[i] = width_q[i];
      if (train_done && !trained_q) begin
        width_d[i] = pcfg_pkg::pcfg_width_t'(train_width[i]);
      end
    end
    width_d[0] = pcfg_pkg::w_x4;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trained_q <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        width_q[i] <= pcfg_pkg::w_x4;
      end
    end else begin
      trained_q <= trained_d;
      width_q <= width_d;
    end
  end

  // Ports 3, 5 and 7 join their even lead at x8 or wider, port 1 never; ports 5..7 join port 4 at x16
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_merge
      if (g == 0 || g == 1 || g == 2 || g == 4) begin : g_lead
        assign absorbed[g] = 1'b0;
      end else if (g == 3) begin : g_pair
        assign absorbed[g] = width_q[2] != pcfg_pkg::w_x4;
      end else begin : g_quad
        assign absorbed[g] = width_q[4] == pcfg_pkg::w_x16 ||
                             (g % 2 == 1 && width_q[g-1] != pcfg_pkg::w_x4);
      end
    end
  endgenerate

  // Configuration decode
  logic dev_ok;
  logic [11:0] off_w;
  logic [SW-1:0] sel_q [8];
  logic [SW-1:0] sel_d [8];
  logic [31:0] wrk_q [8][WRK_DEPTH];
  logic [31:0] wrk_d [8][WRK_DEPTH];
  logic [31:0] rdata_d;
  logic abort_d;

  assign dev_ok = cfg_dev != 3'h1;
  assign off_w = {cfg_off[11:2], 2'b00};
  assign cmd_if.rd_dev = cfg_dev;
  assign cmd_if.wr_dev = cfg_dev;
  assign cmd_if.wr_data = cfg_wdata[15:0];
  assign cmd_if.wr_be = cfg_be[1:0];
  // Absorbed ports take config writes too
  assign cmd_if.wr_en = cfg_req && cfg_we && dev_ok && off_w == `PCFG_OFF_CMD;

  always_comb begin
    sel_d = sel_q;
    wrk_d = wrk_q;
    rdata_d = 32'h0000_0000;
    abort_d = 1'b0;
    if (cfg_req && !dev_ok) begin
      rdata_d = `PCFG_ALL_ONES;
      abort_d = 1'b1;
    end else if (cfg_req && off_w >= `PCFG_OFF_EXT && !cfg_ext) begin
      rdata_d = 32'h0000_0000;
    end else if (cfg_req) begin
      case (off_w)
        `PCFG_OFF_CMD: rdata_d = {16'h0000, cmd_if.rd_data};
        // Pointers fit one byte below 0x100
        `PCFG_OFF_CAPPTR: rdata_d = {24'h00_0000, 8'(`PCFG_OFF_MSI)};
        `PCFG_OFF_MSI: rdata_d = {16'h0000, 8'(`PCFG_OFF_PEX), `PCFG_ID_MSI};
        `PCFG_OFF_PEX: rdata_d = {16'h0000, 8'(`PCFG_OFF_HP), `PCFG_ID_PEX};
        `PCFG_OFF_HP: rdata_d = {24'h00_0000, `PCFG_ID_HP};
        `PCFG_OFF_WSEL: begin
          rdata_d = 32'(sel_q[cfg_dev]);
          if (cfg_we && cfg_be[0]) begin
            sel_d[cfg_dev] = cfg_wdata[SW-1:0];
          end
        end
        `PCFG_OFF_WDAT: begin
          rdata_d = wrk_q[cfg_dev][sel_q[cfg_dev]];
          if (cfg_we) begin
            for (int b = 0; b < 4; b++) begin
              if (cfg_be[b]) begin
                wrk_d[cfg_dev][sel_q[cfg_dev]][b*8 +: 8] = cfg_wdata[b*8 +: 8];
              end
            end
          end
        end
        // Only extended entry, so its next pointer ends the list
        `PCFG_OFF_EXT: rdata_d = {12'h000, `PCFG_EXT_VER, `PCFG_EXT_ID};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_ack_q <= 1'b0;
      cfg_abort_q <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
        sel_q[i] <= '0;
        for (int j = 0; j < WRK_DEPTH; j++) begin
          wrk_q[i][j] <= 32'h0000_0000;
        end
      end
    end else begin
      cfg_ack_q <= cfg_req;
      cfg_abort_q <= abort_d;
      cfg_rdata_q <= rdata_d;
      sel_q <= sel_d;
      wrk_q <= wrk_d;
    end
  end

  // Non-configuration access and interrupt gating
  logic acc_bad;
  logic [7:0] fwd_d, intx_d;
  assign acc_bad = absorbed[acc_dev] || acc_dev == 3'h1;

  always_comb begin
    fwd_d = 8'h00;
    if (acc_req && !acc_bad) begin
      fwd_d[acc_dev] = 1'b1;
    end
    // Hot-plug and power events count only in legacy mode
    intx_d = (port_err_evt | root_err_msg | (hotplug_powermgmt_events_evt & {8{legacy_mode}})) &
             ~cmd_if.inhibit;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_ack_q <= 1'b0;
      acc_abort_q <= 1'b0;
      acc_rdata_q <= 32'h0000_0000;
      acc_fwd_q <= 8'h00;
      hub_intx_q <= 8'h00;
      msg_fwd_q <= 8'h00;
      port_absorbed_q <= 8'h00;
    end else begin
      acc_ack_q <= acc_req;
      acc_abort_q <= acc_req && acc_bad;
      acc_rdata_q <= (acc_req && acc_bad) ? `PCFG_ALL_ONES : 32'h0000_0000;
      acc_fwd_q <= fwd_d;
      hub_intx_q <= intx_d;
      msg_fwd_q <= dn_msg;
      port_absorbed_q <= absorbed;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  abort_all_ones_a: assert property (
      acc_req && acc_bad
      |=> acc_abort_q && acc_rdata_q == 32'hffff_ffff && acc_fwd_q == 8'h00)
    else $error("absorbed access not aborted");
  cfg_always_ack_a: assert property (
      cfg_req && dev_ok |=> cfg_ack_q && !cfg_abort_q)
    else $error("config access did not complete");
  south_never_merged_a: assert property (
      !port_absorbed_q[0] && width_q[0] == pcfg_pkg::w_x4)
    else $error("port 0 merged");
  width_latched_a: assert property (
      trained_q |=> $stable(width_q[2]) && $stable(width_q[4]))
    else $error("width changed after training");
  inhibit_gates_a: assert property (
      cmd_if.inhibit[2] |=> !hub_intx_q[2])
    else $error("inhibited port raised interrupt");
  msg_forward_a: assert property (
      dn_msg[3] |=> msg_fwd_q[3])
    else $error("downstream message blocked");
  cmd_reserved_a: assert property (
      cfg_req && off_w == 12'h004 && dev_ok |=> cfg_rdata_q[31:11] == 21'h0)
    else $error("reserved command bits set");
  // Write, one quiet cycle, then read back of the same device
  cmd_rw_a: assert property (
      cfg_req && cfg_we && off_w == 12'h004 && cfg_be[1] && dev_ok ##1 !cfg_req ##1
      cfg_req && !cfg_we && off_w == 12'h004 && $past(cfg_dev, 2) == cfg_dev
      |=> cfg_rdata_q[10] == $past(cfg_wdata[10], 3))
    else $error("command bit 10 lost");
  legacy_ext_a: assert property (
      cfg_req && !cfg_ext && off_w >= 12'h100 && dev_ok |=> cfg_rdata_q == 32'h0)
    else $error("extended space seen by legacy cycle");
  ext_start_a: assert property (
      cfg_req && cfg_ext && off_w == 12'h100 && dev_ok
      |=> cfg_rdata_q[15:0] == 16'h0001 && cfg_rdata_q[31:20] == 12'h000)
    else $error("extended list not at 0x100");
  cap_chain_a: assert property (
      cfg_req && off_w == 12'h050 && dev_ok |=> cfg_rdata_q[15:8] == 8'h60)
    else $error("capability chain broken");
  wrk_sel_a: assert property (
      cfg_req && cfg_we && off_w == 12'h074 && cfg_be[0] && dev_ok
      |=> sel_q[$past(cfg_dev)] == $past(cfg_wdata[SW-1:0]))
    else $error("select not stored");

  x8_merge_c: cover property (trained_q && port_absorbed_q[3]);
  x16_merge_c: cover property (trained_q && port_absorbed_q[7] && port_absorbed_q[5]);
  abort_seen_c: cover property (acc_abort_q);
  intx_seen_c: cover property (hub_intx_q != 8'h00);
endmodule : pcfg_port_space
